// file: verilog/ccsf_pkg.sv
// package: register map, field positions and constants of the clock csr flags block
package ccsf_pkg;
   localparam int          ADDR_W        = 4;
   localparam int          DATA_W        = 32;
   // byte addresses of the registers
   localparam logic [3:0]  CSR_OFFS      = 4'h0;
   localparam logic [3:0]  PRESET_OFFS   = 4'h4;
   localparam logic [3:0]  IRQ_STAT_OFFS = 4'h8;
   localparam logic [3:0]  IRQ_MASK_OFFS = 4'hC;
   // clock_control_status field positions
   localparam int          START_BIT     = 0;
   localparam int          WRAPIE_BIT    = 6;
   localparam int          WRAPF_BIT     = 7;
   localparam int          SIM1_BIT      = 8;
   localparam int          SIM2_BIT      = 9;
   localparam int          OSCSTEP_BIT   = 10;
   localparam int          OSCDIS_BIT    = 11;
   localparam int          OVERRUN_BIT   = 12;
   localparam int          ARM2_BIT      = 13;
   localparam int          T2IE_BIT      = 14;
   localparam int          T2F_BIT       = 15;
   localparam logic [15:0] CSR_RESET     = 16'h0000;
   localparam logic [15:0] CSR_WMASK     = 16'hF8C1;
   // interrupt status bits
   localparam int          EV_WRAP       = 0;
   localparam int          EV_TRIG2      = 1;
   localparam int          EV_OVERRUN    = 2;
   localparam int          EV_N          = 3;
   localparam logic [2:0]  EV_RESET      = 3'h0;
   // oscillator rate versus device clock
   localparam int          CLK_HZ        = 25_000_000;
   localparam int          OSC_HZ        = 10_000_000;
   // one oscillator tick per this many device clocks, rounded down
   localparam int          OSC_DIV       = (CLK_HZ / OSC_HZ < 1) ? 1 : CLK_HZ / OSC_HZ;
   localparam logic [1:0]  OSC_DIV_M1    = 2'(OSC_DIV - 1);

   typedef struct packed {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [3:0]  sel;
      logic [3:0]  adr;
      logic [31:0] dat;
   } ccsf_wb_req_t;

   typedef struct packed {
      logic        ack;
      logic [31:0] dat;
   } ccsf_wb_rsp_t;

   typedef enum logic [1:0] {
      IRQ_NONE  = 2'b01,
      IRQ_WRAP  = 2'b10
   } ccsf_irqsel_t;
endpackage : ccsf_pkg

// file: verilog/ccsf_top.sv
// clock csr flag/maintenance block with wishbone slave and 16-bit counter
//
// Implementation choices: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ps
module ccsf_top #(
   parameter int CNT_W = 16
) (
   input  wire logic                 clk,
   input  wire logic                 sys_rst,
   input  wire ccsf_pkg::ccsf_wb_req_t wbReq,
   output      ccsf_pkg::ccsf_wb_rsp_t wbRsp,
   input  wire logic                 externalTrigger1,
   input  wire logic                 externalTrigger2,
   output      logic                 irq,
   output      logic                 wrapIrqReq,
   output      logic                 trigger2IrqReq,
   output      logic [CNT_W-1:0]     countValue
);
   import ccsf_pkg::*;

   logic [15:0]      csr_ff;
   logic [15:0]      nxt_csr;
   logic [CNT_W-1:0] preset_ff;
   logic [CNT_W-1:0] cnt_ff;
   logic [CNT_W-1:0] nxt_cnt;
   logic [1:0]       div_ff;
   logic             ack_ff;
   logic [31:0]      rdat_ff;
   logic             startPrev_ff;
   logic [EV_N-1:0]  evStat_ff;
   logic [EV_N-1:0]  evMask_ff;
   logic             simStep_ff;
   logic             simTrig1_ff;
   logic             simTrig2_ff;

   // bus decode
   wire busReq   = wbReq.cyc && wbReq.stb && !ack_ff;
   wire selCsr   = (wbReq.adr == CSR_OFFS);
   wire selPre   = (wbReq.adr == PRESET_OFFS);
   wire selStat  = (wbReq.adr == IRQ_STAT_OFFS);
   wire selMask  = (wbReq.adr == IRQ_MASK_OFFS);
   wire wrStb    = busReq && wbReq.we;
   wire wrCsr    = wrStb && selCsr;
   wire wrPre    = wrStb && selPre;
   wire wrStat   = wrStb && selStat;
   wire wrMask   = wrStb && selMask;

   function automatic logic [15:0] laneMerge(input logic [15:0] old, input logic [31:0] d,
                                             input logic [3:0] s);
      laneMerge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
   endfunction : laneMerge

   wire [15:0] csrWr  = laneMerge(csr_ff, wbReq.dat, wbReq.sel);
   // simulate bits fire only for lanes actually written
   wire        hiLane = wbReq.sel[1];
   // one pulse per bus transfer: busReq is gated off by ack_ff
   wire simStep  = wrCsr && hiLane && wbReq.dat[OSCSTEP_BIT];
   wire simTrig2 = wrCsr && hiLane && wbReq.dat[SIM2_BIT];
   wire simTrig1 = wrCsr && hiLane && wbReq.dat[SIM1_BIT];

   wire start     = csr_ff[START_BIT];
   wire startRise = start && !startPrev_ff;
   wire oscDis    = csr_ff[OSCDIS_BIT];

   // internal 10 MHz tick approximated by a divider of the device clock
   wire oscTick  = (div_ff == OSC_DIV_M1) && !oscDis;
   wire cntStep  = oscTick || simStep_ff;
   wire wrapEv   = start && cntStep && (cnt_ff == {CNT_W{1'b1}});
   wire trig2Ev  = (externalTrigger2 || simTrig2_ff)
                   && (start || csr_ff[ARM2_BIT]);
   wire trig1Ev  = externalTrigger1 || simTrig1_ff;
   wire overrunEv = (wrapEv && csr_ff[WRAPF_BIT])
                    || (trig2Ev && csr_ff[T2F_BIT]);

   always_comb begin
      nxt_csr = csr_ff;
      if (wrCsr) begin
         nxt_csr = csrWr & CSR_WMASK;
         // flags only clear by write; writing one keeps value
         nxt_csr[WRAPF_BIT] = csr_ff[WRAPF_BIT] & csrWr[WRAPF_BIT];
         nxt_csr[T2F_BIT]   = csr_ff[T2F_BIT] & csrWr[T2F_BIT];
         nxt_csr[OVERRUN_BIT] = csr_ff[OVERRUN_BIT] & csrWr[OVERRUN_BIT];
      end
      if (startRise) begin
         nxt_csr[WRAPF_BIT]   = 1'b0;
         nxt_csr[OVERRUN_BIT] = 1'b0;
      end
      // hardware sets win over any clear
      if (wrapEv) begin
         nxt_csr[WRAPF_BIT] = 1'b1;
      end
      if (trig2Ev) begin
         nxt_csr[T2F_BIT] = 1'b1;
      end
      if (overrunEv) begin
         nxt_csr[OVERRUN_BIT] = 1'b1;
      end
   end

   always_comb begin
      if (!start) begin
         nxt_cnt = '0;
      end else if (cntStep) begin
         nxt_cnt = cnt_ff + 1'b1;
      end else begin
         nxt_cnt = cnt_ff;
      end
   end

   // interrupt requests are levels, so clearing a flag withdraws them
   wire wrapReq  = csr_ff[WRAPF_BIT] && csr_ff[WRAPIE_BIT];
   wire trig2Req = csr_ff[T2F_BIT] && csr_ff[T2IE_BIT];
   wire ccsf_irqsel_t irqSel = wrapReq ? IRQ_WRAP : IRQ_NONE;
   assign wrapIrqReq     = (irqSel == IRQ_WRAP);
   assign trigger2IrqReq = trig2Req && (irqSel != IRQ_WRAP);
   assign irq        = |(evStat_ff & evMask_ff);
   assign countValue = cnt_ff;

   wire [EV_N-1:0] evIn = {overrunEv, trig2Ev, wrapEv};
   wire [EV_N-1:0] evClr = wrStat ? wbReq.dat[EV_N-1:0] : '0;

   wire [31:0] rdMux = selCsr  ? {16'h0000, csr_ff} :
                       selPre  ? {{(32-CNT_W){1'b0}}, preset_ff} :
                       selStat ? {{(32-EV_N){1'b0}}, evStat_ff} :
                       selMask ? {{(32-EV_N){1'b0}}, evMask_ff} : 32'h0000_0000;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         csr_ff       <= CSR_RESET;
         cnt_ff       <= '0;
         div_ff       <= '0;
         startPrev_ff <= 1'b0;
         simStep_ff   <= 1'b0;
         simTrig1_ff  <= 1'b0;
         simTrig2_ff  <= 1'b0;
      end else begin
         csr_ff       <= nxt_csr;
         cnt_ff       <= nxt_cnt;
         div_ff       <= (div_ff == OSC_DIV_M1) ? 2'd0 : div_ff + 2'd1;
         startPrev_ff <= start;
         simStep_ff   <= simStep;
         simTrig1_ff  <= simTrig1;
         simTrig2_ff  <= simTrig2;
      end
   end

   // preset register loads the counter on start in a fuller design
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         preset_ff <= '0;
      end else if (wrPre) begin
         preset_ff <= wbReq.dat[CNT_W-1:0];
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < EV_N; gi++) begin : g_ev
         always_ff @(posedge clk) begin
            if (sys_rst) begin
               evStat_ff[gi] <= EV_RESET[gi];
               evMask_ff[gi] <= EV_RESET[gi];
            end else begin
               // set wins over write-one-to-clear
               evStat_ff[gi] <= evIn[gi] | (evStat_ff[gi] & ~evClr[gi]);
               if (wrMask && wbReq.sel[0]) begin
                  evMask_ff[gi] <= wbReq.dat[gi];
               end
            end
         end
      end
   endgenerate

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ack_ff  <= 1'b0;
         rdat_ff <= 32'h0000_0000;
      end else begin
         ack_ff  <= busReq;
         rdat_ff <= busReq ? rdMux : rdat_ff;
      end
   end

   assign wbRsp.ack = ack_ff;
   assign wbRsp.dat = rdat_ff;

   // trigger 1 has no sink here beyond the status-free event; kept for rate source
   logic trig1Seen_ff;
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         trig1Seen_ff <= 1'b0;
      end else begin
         trig1Seen_ff <= trig1Ev;
      end
   end

   wrap_sets_flag_a: assert property (@(posedge clk) disable iff (sys_rst)
      wrapEv |=> csr_ff[WRAPF_BIT]) else $error("wrap flag not set");
   overrun_wrap_a: assert property (@(posedge clk) disable iff (sys_rst)
      (wrapEv && csr_ff[WRAPF_BIT]) |=> csr_ff[OVERRUN_BIT]) else $error("overrun missed");
   overrun_trig2_a: assert property (@(posedge clk) disable iff (sys_rst)
      (trig2Ev && csr_ff[T2F_BIT]) |=> csr_ff[OVERRUN_BIT]) else $error("overrun t2 missed");
   start_clears_a: assert property (@(posedge clk) disable iff (sys_rst)
      (startRise && !wrapEv && !overrunEv) |=> !csr_ff[WRAPF_BIT] && !csr_ff[OVERRUN_BIT])
      else $error("start edge did not clear flags");
   sim_reads_zero_a: assert property (@(posedge clk) disable iff (sys_rst)
      csr_ff[OSCSTEP_BIT:SIM1_BIT] == 3'b000) else $error("simulate bit reads one");
   sim_one_pulse_a: assert property (@(posedge clk) disable iff (sys_rst)
      simStep_ff |=> !simStep_ff) else $error("step pulse longer than one cycle");
   osc_disabled_a: assert property (@(posedge clk) disable iff (sys_rst)
      (oscDis && start && !simStep_ff) |=> cnt_ff == $past(cnt_ff))
      else $error("counter moved with oscillator off");
   stop_zero_a: assert property (@(posedge clk) disable iff (sys_rst)
      !start |=> cnt_ff == '0) else $error("counter not zeroed");
   wrap_irq_a: assert property (@(posedge clk) disable iff (sys_rst)
      wrapIrqReq == (csr_ff[WRAPF_BIT] && csr_ff[WRAPIE_BIT])) else $error("wrap irq wrong");
   prio_a: assert property (@(posedge clk) disable iff (sys_rst)
      wrapIrqReq |-> !trigger2IrqReq) else $error("priority broken");

   // overrun flag: only the two overrun events set it, write of zero or start edge clears it
   overrun_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
      (csr_ff[OVERRUN_BIT] && !wrCsr && !startRise) |=> csr_ff[OVERRUN_BIT])
      else $error("overrun flag lost");

   overrun_wrclr_a: assert property (@(posedge clk) disable iff (sys_rst)
      (wrCsr && !csrWr[OVERRUN_BIT] && !overrunEv) |=> !csr_ff[OVERRUN_BIT])
      else $error("overrun flag not cleared by write");

   overrun_cause_a: assert property (@(posedge clk) disable iff (sys_rst)
      (!csr_ff[OVERRUN_BIT] && !overrunEv) |=> !csr_ff[OVERRUN_BIT])
      else $error("overrun flag set without cause");

   // oscillator disable is a plain read/write bit gating the divider tick
   oscdis_rw_a: assert property (@(posedge clk) disable iff (sys_rst)
      (wrCsr && hiLane) |=> csr_ff[OSCDIS_BIT] == $past(wbReq.dat[OSCDIS_BIT]))
      else $error("oscillator disable not written");

   tick_blocked_a: assert property (@(posedge clk) disable iff (sys_rst)
      oscDis |-> !oscTick) else $error("tick with oscillator off");

   step_counts_a: assert property (@(posedge clk) disable iff (sys_rst)
      (start && simStep_ff) |=> cnt_ff == $past(cnt_ff) + 1'b1)
      else $error("step did not advance counter");

   step_source_a: assert property (@(posedge clk) disable iff (sys_rst)
      simStep_ff |-> $past(wrCsr)) else $error("step without program write");

   cnt_still_a: assert property (@(posedge clk) disable iff (sys_rst)
      (start && !cntStep) |=> cnt_ff == $past(cnt_ff))
      else $error("counter moved without a step");

   // each simulate write is one internal pulse of one cycle
   trig2_pulse_a: assert property (@(posedge clk) disable iff (sys_rst)
      simTrig2_ff |=> !simTrig2_ff) else $error("trigger2 pulse too long");

   trig1_pulse_a: assert property (@(posedge clk) disable iff (sys_rst)
      simTrig1_ff |=> !simTrig1_ff) else $error("trigger1 pulse too long");

   // counts step pulses since the last bus request, so a repeat shows up
   logic [1:0] stepPulses_ff;
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         stepPulses_ff <= 2'd0;
      end else if (busReq) begin
         stepPulses_ff <= 2'd0;
      end else if (simStep_ff && stepPulses_ff != 2'd3) begin
         stepPulses_ff <= stepPulses_ff + 2'd1;
      end
   end

   step_once_a: assert property (@(posedge clk) disable iff (sys_rst)
      stepPulses_ff <= 2'd1) else $error("more than one step per write");

   trig1_seen_a: assert property (@(posedge clk) disable iff (sys_rst)
      (externalTrigger1 || simTrig1_ff) |=> trig1Seen_ff)
      else $error("trigger1 firing lost");

   // trigger 2 flag follows the firing only while start or arm is set
   sim2_flag_a: assert property (@(posedge clk) disable iff (sys_rst)
      (simTrig2_ff && start) |=> csr_ff[T2F_BIT]) else $error("simulated trigger2 lost");

   ext2_flag_a: assert property (@(posedge clk) disable iff (sys_rst)
      (externalTrigger2 && csr_ff[ARM2_BIT]) |=> csr_ff[T2F_BIT])
      else $error("armed trigger2 lost");

   t2_cause_a: assert property (@(posedge clk) disable iff (sys_rst)
      (!csr_ff[T2F_BIT] && !trig2Ev) |=> !csr_ff[T2F_BIT])
      else $error("trigger2 flag set without cause");

   // wrap flag: counter overflow sets it, write of zero or start edge clears it
   wrap_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
      (csr_ff[WRAPF_BIT] && !wrCsr && !startRise) |=> csr_ff[WRAPF_BIT])
      else $error("wrap flag lost");

   wrap_wrclr_a: assert property (@(posedge clk) disable iff (sys_rst)
      (wrCsr && !csrWr[WRAPF_BIT] && !wrapEv) |=> !csr_ff[WRAPF_BIT])
      else $error("wrap flag not cleared by write");

   wrap_cause_a: assert property (@(posedge clk) disable iff (sys_rst)
      (!csr_ff[WRAPF_BIT] && !wrapEv) |=> !csr_ff[WRAPF_BIT])
      else $error("wrap flag set without overflow");

   wrap_drop_a: assert property (@(posedge clk) disable iff (sys_rst)
      $fell(csr_ff[WRAPF_BIT]) |-> !wrapIrqReq) else $error("request not withdrawn");

   ie_rise_a: assert property (@(posedge clk) disable iff (sys_rst)
      ($rose(csr_ff[WRAPIE_BIT]) && csr_ff[WRAPF_BIT]) |-> wrapIrqReq)
      else $error("late enable did not request");

   wrap_no_req_a: assert property (@(posedge clk) disable iff (sys_rst)
      !csr_ff[WRAPF_BIT] |-> !wrapIrqReq) else $error("request without wrap flag");

   t2_req_a: assert property (@(posedge clk) disable iff (sys_rst)
      trigger2IrqReq == (csr_ff[T2F_BIT] && csr_ff[T2IE_BIT] && !wrapIrqReq))
      else $error("trigger2 request wrong");

   // status bits are sticky copies of the events
   stat_wrap_a: assert property (@(posedge clk) disable iff (sys_rst)
      wrapEv |=> evStat_ff[EV_WRAP]) else $error("wrap status not set");

   stat_trig2_a: assert property (@(posedge clk) disable iff (sys_rst)
      trig2Ev |=> evStat_ff[EV_TRIG2]) else $error("trigger2 status not set");

   stat_overrun_a: assert property (@(posedge clk) disable iff (sys_rst)
      overrunEv |=> evStat_ff[EV_OVERRUN]) else $error("overrun status not set");

   // bus answer: one registered ack per request, one cycle long
   ack_answer_a: assert property (@(posedge clk) disable iff (sys_rst)
      busReq |=> ack_ff) else $error("request not answered");

   ack_one_a: assert property (@(posedge clk) disable iff (sys_rst)
      ack_ff |=> !ack_ff) else $error("ack longer than one cycle");
endmodule : ccsf_top

// file: dv/ccsf_trig_model.sv
// far-side model: trigger sources that fire for one device clock each
`timescale 1ns/1ps
module ccsf_trig_model (
   input  wire logic clk,
   input  wire logic fire1,
   input  wire logic fire2,
   output      logic trig1 = 1'b0,
   output      logic trig2 = 1'b0
);
   // registered, so a firing never lands in the same step as the bench request
   always @(posedge clk) begin
      trig1 <= fire1;
      trig2 <= fire2;
   end
endmodule : ccsf_trig_model

// file: dv/ccsf_top_test.sv
// self-checking bench of the clock csr flags block
`timescale 1ns/1ps
module ccsf_top_test;
   import ccsf_pkg::*;
   logic         clk     = 1'b0;
   logic         sysRst  = 1'b1;
   ccsf_wb_req_t wbReq   = '0;
   ccsf_wb_rsp_t wbRsp;
   logic         fire1   = 1'b0;
   logic         fire2   = 1'b0;
   logic         trig1;
   logic         trig2;
   logic         irq;
   logic         wrapReq;
   logic         t2Req;
   logic [3:0]   cnt;
   logic [31:0]  rd;
   int           errorCnt = 0;
   int           nChecks  = 0;

   always #20 clk = ~clk;

   // short counter so a wrap takes sixteen steps
   ccsf_top #(.CNT_W(4)) ccsf_top_inst (.clk(clk), .sys_rst(sysRst), .wbReq(wbReq),
      .wbRsp(wbRsp), .externalTrigger1(trig1), .externalTrigger2(trig2), .irq(irq),
      .wrapIrqReq(wrapReq), .trigger2IrqReq(t2Req), .countValue(cnt));
   ccsf_trig_model ccsf_trig_model_inst (.clk(clk), .fire1(fire1), .fire2(fire2),
      .trig1(trig1), .trig2(trig2));

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      nChecks++;
      if (seen !== exp) begin
         errorCnt++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick

   // classic cycle: hold until ack is sampled, then release for a cycle
   task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      wbReq <= '{cyc: 1'b1, stb: 1'b1, we: w, sel: 4'hF, adr: a, dat: d};
      do begin
         @(posedge clk);
         n++;
      end while (wbRsp.ack !== 1'b1);
      rd = wbRsp.dat;
      chk("ackLat", n, 32'h0000_0002);
      wbReq <= '0;
      @(posedge clk);
   endtask : wb

   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      wb(1'b1, a, {16'h0000, d});
   endtask : wr

   task automatic rc(input string nm, input logic [3:0] a, input logic [15:0] e);
      wb(1'b0, a, 32'h0000_0000);
      chk(nm, rd, {16'h0000, e});
   endtask : rc

   // step bit added to a full csr image, so flags are kept by writing ones
   task automatic steps(input logic [15:0] base, input int n);
      repeat (n) wr(CSR_OFFS, base | 16'h0400);
      tick(3);
   endtask : steps

   task automatic t_reset;
      rc("csr", CSR_OFFS, 16'h0000);
      chk("irq", irq, 1'b0);
      $display("done reset");
   endtask : t_reset

   task automatic t_maint;
      wr(CSR_OFFS, 16'h0700);
      rc("csr", CSR_OFFS, 16'h0000);
      wr(CSR_OFFS, 16'h0801);
      tick(8);
      chk("cnt", cnt, 4'h0);
      steps(16'h0801, 1);
      chk("cnt", cnt, 4'h1);
      rc("csr", CSR_OFFS, 16'h0801);
      $display("done maint");
   endtask : t_maint

   task automatic t_wrap;
      steps(16'h0801, 15);
      chk("cnt", cnt, 4'h0);
      rc("csr", CSR_OFFS, 16'h0881);
      chk("wrapReq", wrapReq, 1'b0);
      chk("irq", irq, 1'b0);
      wr(CSR_OFFS, 16'h08C1);
      tick(1);
      chk("wrapReq", wrapReq, 1'b1);
      steps(16'h08C1, 16);
      rc("csr", CSR_OFFS, 16'h18C1);
      chk("wrapReq", wrapReq, 1'b1);
      $display("done wrap");
   endtask : t_wrap

   task automatic t_trig2;
      wr(CSR_OFFS, 16'h5AC1);
      tick(2);
      rc("csr", CSR_OFFS, 16'hD8C1);
      chk("t2Req", t2Req, 1'b0);
      wr(CSR_OFFS, 16'hC8C1);
      rc("csr", CSR_OFFS, 16'hC8C1);
      @(posedge clk);
      fire2 <= 1'b1;
      fire1 <= 1'b1;
      @(posedge clk);
      fire2 <= 1'b0;
      fire1 <= 1'b0;
      tick(2);
      rc("csr", CSR_OFFS, 16'hD8C1);
      wr(CSR_OFFS, 16'hD841);
      tick(1);
      chk("wrapReq", wrapReq, 1'b0);
      chk("t2Req", t2Req, 1'b1);
      $display("done trigger");
   endtask : t_trig2

   task automatic t_start;
      steps(16'hD841, 1);
      chk("cnt", cnt, 4'h1);
      wr(CSR_OFFS, 16'hD840);
      tick(1);
      chk("cnt", cnt, 4'h0);
      wr(CSR_OFFS, 16'hD841);
      rc("csr", CSR_OFFS, 16'hC841);
      $display("done start");
   endtask : t_start

   task automatic t_irq;
      rc("stat", IRQ_STAT_OFFS, 16'h0007);
      wr(IRQ_MASK_OFFS, 16'h0001);
      tick(1);
      chk("irq", irq, 1'b1);
      wr(IRQ_STAT_OFFS, 16'h0007);
      tick(1);
      chk("irq", irq, 1'b0);
      rc("hole", 4'h6, 16'h0000);
      $display("done irq");
   endtask : t_irq

   task automatic stop_test;
      $display("checks %0d mismatches %0d", nChecks, errorCnt);
      if (errorCnt == 0 && nChecks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : stop_test

   initial begin
      repeat (20000) @(posedge clk);
      errorCnt++;
      stop_test();
   end

   initial begin
      repeat (12) @(posedge clk);
      sysRst <= 1'b0;
      t_reset();
      t_maint();
      t_wrap();
      t_trig2();
      t_start();
      t_irq();
      stop_test();
   end
endmodule : ccsf_top_test
